// ===== bench/psc_freq_ctrl_assertions.sv
// Checker of the frequency control block, watching top ports only.
// Assumes it is bound to psc_freq_ctrl and the tick comes from pclk logic.
`timescale 1ns/1ps
`default_nettype none
module psc_freq_ctrl_assertions (
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pready, // APB ready
   input wire logic pslverr, // APB error
   input wire logic pll_osc_tick, // Oscillator tick
   input wire logic pll_lock_det, // Lock level
   input wire logic serial_latch_strobe, // Load strobe
   input wire logic [psc_pkg::PRESCALE_W-1:0] prescale_val, // Prescale
   input wire logic [psc_pkg::FEEDBACK_W-1:0] feedback_val, // Feedback
   input wire logic synth_out_p, // Output true
   input wire logic synth_out_n, // Output complement
   input wire logic locked_n // Lock indicator
);
   // ------------------------------
   // Checks
   // ------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_apb_one_wait: assert property ((psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready)
      else $error("pready not after one wait state");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_err_with_ready: assert property (pslverr |-> pready && psel && penable)
      else $error("pslverr outside an access");
   a_out_pair: assert property (synth_out_n == !synth_out_p)
      else $error("outputs not complementary");
   a_edge_on_tick: assert property ($rose(synth_out_p) |-> $past(pll_osc_tick))
      else $error("output edge off an oscillator tick");
   a_lock_needs_det: assert property ($fell(locked_n) |-> $past(pll_lock_det, 3))
      else $error("lock shown without detector");
   a_loss_raises: assert property ((!locked_n && !pll_lock_det) |-> ##[1:4] locked_n)
      else $error("lock loss not shown");
   a_cfg_on_strobe: assert property (($changed(prescale_val) || $changed(feedback_val))
      |-> $past(serial_latch_strobe, 3))
      else $error("divider changed without load");

   c_locked: cover property ($fell(locked_n));
   c_running: cover property ($rose(synth_out_p));
   c_refused: cover property (pslverr);
endmodule
`default_nettype wire

// ===== bench/psc_freq_ctrl_tb.sv
// Bench of the frequency control block.
// Assumes the package and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module psc_freq_ctrl_tb;
   localparam int LOCKMAX = 50;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, rerr, sck, sdi, sld, out_p, out_n, locked_n, irq;
   logic oe_pin = 1'b1;
   logic det = 1'b0;
   logic tick = 1'b0;
   logic [1:0] tcnt = 2'h0;
   logic [4:0] pre;
   logic [9:0] fb;
   int err_total = 0;
   int n_tests = 0;
   int per;

   // ------------------------------
   // Environment
   // ------------------------------
   always #5 pclk = ~pclk;
   // A tick every third cycle makes an output period of 3 * ratio cycles
   always @(posedge pclk) begin
      tcnt <= (tcnt == 2'h2) ? 2'h0 : tcnt + 2'h1;
      tick <= (tcnt == 2'h2);
   end

   psc_freq_ctrl #(.LOCK_MAX_CYCLES(LOCKMAX)) psc_freq_ctrl_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .serial_shift_clk(sck), .serial_in_bit(sdi),
      .serial_latch_strobe(sld), .out_enable_pin(oe_pin), .pll_lock_det(det), .pll_osc_tick(tick),
      .prescale_val(pre), .feedback_val(fb), .synth_out_p(out_p), .synth_out_n(out_n),
      .locked_n(locked_n), .irq(irq));
   psc_host_model psc_host_model_inst (.serial_shift_clk(sck), .serial_in_bit(sdi), .serial_latch_strobe(sld));

   // ------------------------------
   // Tasks
   // ------------------------------
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) err_total++;
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
   endtask

   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, exp, rd & m);
   endtask

   task automatic load(input logic [17:0] v, input int n);
      psc_host_model_inst.send(v, n);
      repeat (20) @(posedge pclk);
   endtask

   task automatic wait_lvl(input logic v, inout int c);
      while (out_p !== v && c < 600) begin
         @(negedge pclk);
         c++;
      end
   endtask

   task automatic measure();
      int k;
      k = 0;
      wait_lvl(1'b0, k);
      wait_lvl(1'b1, k);
      per = 0;
      wait_lvl(1'b0, per);
      wait_lvl(1'b1, per);
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      #500000;
      err_total++;
      give_verdict();
   end

   // ------------------------------
   // Tests
   // ------------------------------
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk("locked_n", 32'h1, {31'h0, locked_n});
      chk("pair", 32'h1, {30'h0, out_p, out_n});
      rchk("ctrl", psc_pkg::REG_CTRL, 32'h1, 32'h1);
      rchk("mask", psc_pkg::REG_IRQ_MASK, 32'hffffffff, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped", 32'h1, {31'h0, rerr});
      chk("unmapped data", 32'h0, rd);
      apb(1'b1, psc_pkg::REG_IRQ_MASK, 32'h3f);
      for (int c = 1; c <= 5; c++) begin
         load({3'(c), 10'h252, 5'h1b}, 18);
         rchk("cfg", psc_pkg::REG_CFG, 32'h3ffff, {14'h0, 3'(c), 10'h252, 5'h1b});
         chk("dividers", {17'h0, 5'h1b, 10'h252}, {17'h0, pre, fb});
         chk("acquiring", 32'h1, {31'h0, locked_n});
         measure();
         chk("period", 3 * (2 ** c), per);
      end
      for (int i = 0; i < 3; i++) begin
         load({((i == 0) ? 3'h0 : 3'(5 + i)), 10'h252, 5'h1b}, 18);
         chk("held pair", 32'h1, {30'h0, out_p, out_n});
         rchk("code ok", psc_pkg::REG_STAT, 32'h4, 32'h0);
         rchk("bad code", psc_pkg::REG_IRQ_STAT, 32'h20, 32'h20);
         apb(1'b1, psc_pkg::REG_IRQ_STAT, 32'h3f);
      end
      load({3'h2, 10'h252, 5'h1b}, 18);
      apb(1'b1, psc_pkg::REG_IRQ_STAT, 32'h3f);
      load({3'h4, 10'h0aa, 5'h03}, 17);
      rchk("frame err", psc_pkg::REG_IRQ_STAT, 32'h10, 32'h10);
      rchk("cfg kept", psc_pkg::REG_CFG, 32'h3ffff, {14'h0, 3'h2, 10'h252, 5'h1b});
      oe_pin <= 1'b0;
      repeat (40) @(posedge pclk);
      chk("oe pair", 32'h1, {30'h0, out_p, out_n});
      rchk("oe sync", psc_pkg::REG_STAT, 32'h8, 32'h0);
      oe_pin <= 1'b1;
      measure();
      chk("period oe", 32'd12, per);
      apb(1'b1, psc_pkg::REG_CTRL, 32'h0);
      repeat (40) @(posedge pclk);
      chk("ctrl pair", 32'h1, {30'h0, out_p, out_n});
      apb(1'b1, psc_pkg::REG_CTRL, 32'h1);
      apb(1'b1, psc_pkg::REG_IRQ_STAT, 32'h3f);
      chk("irq clear", 32'h0, {31'h0, irq});
      det <= 1'b1;
      repeat (10) @(posedge pclk);
      @(negedge pclk);
      chk("locked", 32'h0, {31'h0, locked_n});
      chk("irq gained", 32'h1, {31'h0, irq});
      rchk("stat lock", psc_pkg::REG_STAT, 32'h1, 32'h1);
      rchk("gained", psc_pkg::REG_IRQ_STAT, 32'h2, 32'h2);
      apb(1'b1, psc_pkg::REG_IRQ_STAT, 32'h3f);
      apb(1'b1, psc_pkg::REG_IRQ_MASK, 32'h3b);
      det <= 1'b0;
      repeat (8) @(posedge pclk);
      @(negedge pclk);
      chk("lost", 32'h1, {31'h0, locked_n});
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, psc_pkg::REG_IRQ_MASK, 32'h3f);
      @(negedge pclk);
      chk("irq lost", 32'h1, {31'h0, irq});
      rchk("lost bit", psc_pkg::REG_IRQ_STAT, 32'h4, 32'h4);
      load({3'h1, 10'h252, 5'h1b}, 18);
      apb(1'b1, psc_pkg::REG_IRQ_STAT, 32'h3f);
      repeat (LOCKMAX + 20) @(posedge pclk);
      rchk("timeout", psc_pkg::REG_IRQ_STAT, 32'h8, 32'h8);
      chk("no lock", 32'h1, {31'h0, locked_n});
      give_verdict();
   end
endmodule

bind psc_freq_ctrl psc_freq_ctrl_assertions psc_freq_ctrl_assertions_inst (.*);
`default_nettype wire

// ===== bench/psc_host_model.sv
// Host model driving the three-wire serial configuration pins.
// Assumes the bench calls send from its main sequence, one frame at a time.
`timescale 1ns/1ps
`default_nettype none
module psc_host_model (
   output logic serial_shift_clk, // Shift clock, still between frames
   output logic serial_in_bit, // Serial data
   output logic serial_latch_strobe // Load strobe
);
   // ------------------------------
   // Frame driver
   // ------------------------------
   initial begin
      serial_shift_clk = 1'b0;
      serial_in_bit = 1'b0;
      serial_latch_strobe = 1'b0;
   end

   // Sends the first n bits of v, msb first, at a 125 ns shift period
   task automatic send(input logic [17:0] v, input int n);
      for (int i = 17; i > 17 - n; i--) begin
         serial_in_bit = v[i];
         #62.5 serial_shift_clk = 1'b1;
         #62.5 serial_shift_clk = 1'b0;
      end
      // Data line flips so a stale bit is not taken for data
      serial_in_bit = ~serial_in_bit;
      #62.5 serial_latch_strobe = 1'b1;
      #125 serial_latch_strobe = 1'b0;
      #62.5;
   endtask
endmodule
`default_nettype wire

// ===== rtl/psc_freq_ctrl.sv
// Frequency control block of a serially programmed clock synthesizer.
// Assumes the three serial pins, the output enable pin and the phase detector's
// lock level arrive asynchronously; the oscillator tick comes from logic on pclk.
//
// Summary of operation
// R1: Drive a 5-bit prescale, 10-bit feedback value and 3-bit output divider code.
// R2: Output divider divides the oscillator by 2, 4, 8, 16 or 32.
// R3: Codes 1..5 select ratios 2..32; codes 0, 6, 7 are invalid.
// R4: Host keeps oscillator between 400 and 850 MHz when choosing dividers.
// R5: Serial interface sets every divider, for preset or custom frequencies.
// R6: Valid divider settings keep the output between 12.5 and 425 MHz.
// R7: Output enable acts only at whole-pulse boundaries, never making runt pulses.
// R8: Enabled outputs toggle; disabled true output low, complement high.
// R9: Lock indicator low while locked, high while not locked.
// R10: Lock indicator goes high at once when phase lock is lost.
// R11: Lock expected within 5 ms after configuration; host waits for lock.
`timescale 1ns/1ps
`default_nettype none
module psc_freq_ctrl #(
   parameter int unsigned LOCK_MAX_CYCLES = psc_pkg::LOCK_MAX_CYC // Lock time limit in pclk cycles
) (
   input wire logic pclk, // APB clock
   input wire logic presetn, // Asynchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire logic serial_shift_clk, // Serial shift clock pin
   input wire logic serial_in_bit, // Serial data pin
   input wire logic serial_latch_strobe, // Serial load strobe pin
   input wire logic out_enable_pin, // Output enable pin
   input wire logic pll_lock_det, // Phase detector lock level
   input wire logic pll_osc_tick, // One pulse per oscillator cycle
   output logic [psc_pkg::PRESCALE_W-1:0] prescale_val, // To input prescaler
   output logic [psc_pkg::FEEDBACK_W-1:0] feedback_val, // To feedback divider
   output logic synth_out_p, // Output clock, true
   output logic synth_out_n, // Output clock, complement
   output logic locked_n, // Lock indicator, low when locked
   output logic irq // Interrupt, level
);

   localparam int unsigned TMR_W = $clog2(LOCK_MAX_CYCLES + 1);
   localparam logic [TMR_W-1:0] TMR_MAX = TMR_W'(LOCK_MAX_CYCLES);
   localparam logic [4:0] FRAME_CNT = 5'(psc_pkg::FRAME_BITS);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [4:0] sync1_r;
   logic [4:0] sync2_r;
   logic sclk_d_r;
   logic serial_latch_strobe_d_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= 5'h00;
         sync2_r <= 5'h00;
      end else begin
         sync1_r <= {pll_lock_det, out_enable_pin, serial_latch_strobe, serial_in_bit, serial_shift_clk};
         sync2_r <= sync1_r;
      end
   end

   logic sclk_s;
   logic serial_in_bit_s;
   logic serial_latch_strobe_s;
   logic oe_s;
   logic det_s;
   assign sclk_s = sync2_r[0];
   assign serial_in_bit_s = sync2_r[1];
   assign serial_latch_strobe_s = sync2_r[2];
   assign oe_s = sync2_r[3];
   assign det_s = sync2_r[4];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_d_r <= 1'b0;
         serial_latch_strobe_d_r <= 1'b0;
      end else begin
         sclk_d_r <= sclk_s;
         serial_latch_strobe_d_r <= serial_latch_strobe_s;
      end
   end

   logic sclk_rise;
   logic serial_latch_strobe_rise;
   assign sclk_rise = sclk_s && !sclk_d_r;
   assign serial_latch_strobe_rise = serial_latch_strobe_s && !serial_latch_strobe_d_r;

   // ----------------------------------------------------------------
   // Serial shift register
   // ----------------------------------------------------------------
   // Data and shift clock pass equal synchroniser depth, so setup and hold carry over
   logic [psc_pkg::FRAME_BITS-1:0] shift_r;
   logic [4:0] bit_cnt_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift_r <= psc_pkg::CFG_RST;
      end else if (sclk_rise) begin
         shift_r <= {shift_r[psc_pkg::FRAME_BITS-2:0], serial_in_bit_s}; // R5
      end
   end

   // Count saturates one past a frame so an overlong frame is also caught
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_cnt_r <= 5'h00;
      end else if (serial_latch_strobe_rise) begin
         bit_cnt_r <= 5'h00;
      end else if (sclk_rise && bit_cnt_r <= FRAME_CNT) begin
         bit_cnt_r <= bit_cnt_r + 5'h01;
      end
   end

   logic frame_ok;
   logic load_ok;
   assign frame_ok = (bit_cnt_r == FRAME_CNT);
   assign load_ok = serial_latch_strobe_rise && frame_ok;

   // ----------------------------------------------------------------
   // Active configuration
   // ----------------------------------------------------------------
   psc_pkg::psc_cfg_t cfg_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r <= psc_pkg::CFG_RST;
      end else if (load_ok) begin
         cfg_r <= psc_pkg::psc_cfg_t'(shift_r); // R5
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescale_val <= 5'h00;
         feedback_val <= 10'h000;
      end else begin
         prescale_val <= cfg_r.prescale; // R1
         feedback_val <= cfg_r.feedback; // R1
      end
   end

   // ----------------------------------------------------------------
   // Lock tracking
   // ----------------------------------------------------------------
   psc_pkg::psc_lock_st_t lk_st_r;
   psc_pkg::psc_lock_st_t lk_st_nxt;
   logic [TMR_W-1:0] tmr_r;
   logic timeout_done_r;

   always_comb begin
      lk_st_nxt = lk_st_r;
      case (lk_st_r)
         psc_pkg::LK_IDLE: begin
            if (load_ok) begin
               lk_st_nxt = psc_pkg::LK_ACQ;
            end
         end
         psc_pkg::LK_ACQ: begin
            if (load_ok) begin
               lk_st_nxt = psc_pkg::LK_ACQ;
            end else if (det_s) begin
               lk_st_nxt = psc_pkg::LK_LOCKED;
            end
         end
         psc_pkg::LK_LOCKED: begin
            if (load_ok || !det_s) begin
               lk_st_nxt = psc_pkg::LK_ACQ; // R10
            end
         end
         default: begin
            lk_st_nxt = psc_pkg::LK_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lk_st_r <= psc_pkg::LK_IDLE;
      end else begin
         lk_st_r <= lk_st_nxt;
      end
   end

   // A fresh configuration restarts the acquisition time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tmr_r <= '0;
         timeout_done_r <= 1'b0;
      end else if (lk_st_nxt != psc_pkg::LK_ACQ || load_ok) begin
         tmr_r <= '0;
         timeout_done_r <= 1'b0;
      end else if (tmr_r < TMR_MAX) begin
         tmr_r <= tmr_r + TMR_W'(1); // R11
      end else begin
         timeout_done_r <= 1'b1;
      end
   end

   logic timeout_hit;
   assign timeout_hit = (lk_st_r == psc_pkg::LK_ACQ) && (tmr_r == TMR_MAX) && !timeout_done_r && !load_ok;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         locked_n <= 1'b1;
      end else begin
         locked_n <= (lk_st_nxt != psc_pkg::LK_LOCKED); // R9 R10
      end
   end

   // ----------------------------------------------------------------
   // Output path
   // ----------------------------------------------------------------
   logic ctrl_out_en_r;
   logic out_running;

   psc_outdiv u_outdiv (
      .clk(pclk),
      .rst_n(presetn),
      .osc_tick(pll_osc_tick),
      .post_code(cfg_r.post_code), // R3 R6
      .out_en(oe_s && ctrl_out_en_r), // R7
      .out_p(synth_out_p),
      .out_n(synth_out_n),
      .running(out_running)
   );

   // ----------------------------------------------------------------
   // Events and interrupt
   // ----------------------------------------------------------------
   psc_pkg::psc_irq_t ev;
   psc_pkg::psc_irq_t irq_stat_r;
   psc_pkg::psc_irq_t irq_stat_nxt;
   logic [psc_pkg::IRQ_W-1:0] irq_mask_r;
   logic [psc_pkg::IRQ_W-1:0] w1c;
   logic bus_wr;
   logic bus_rd;

   always_comb begin
      ev.cfg_loaded = load_ok;
      ev.lock_gained = (lk_st_r != psc_pkg::LK_LOCKED) && (lk_st_nxt == psc_pkg::LK_LOCKED);
      ev.lock_lost = (lk_st_r == psc_pkg::LK_LOCKED) && !det_s; // R10
      ev.lock_timeout = timeout_hit; // R11
      ev.frame_err = serial_latch_strobe_rise && !frame_ok;
      ev.bad_code = load_ok && !psc_pkg::code_ok(shift_r[psc_pkg::FRAME_BITS-1 -: psc_pkg::POSTDIV_W]); // R3
   end

   assign w1c = (bus_wr && paddr == psc_pkg::REG_IRQ_STAT) ? pwdata[psc_pkg::IRQ_W-1:0] : 6'h00;
   // A new event wins over a clear in the same cycle
   assign irq_stat_nxt = (irq_stat_r & ~w1c) | ev;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_r <= '0;
      end else begin
         irq_stat_r <= irq_stat_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_nxt & irq_mask_nxt());
      end
   end

   function automatic logic [psc_pkg::IRQ_W-1:0] irq_mask_nxt();
      irq_mask_nxt = (bus_wr && paddr == psc_pkg::REG_IRQ_MASK) ? pwdata[psc_pkg::IRQ_W-1:0] : irq_mask_r;
   endfunction

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   // One wait state keeps read data and ready straight from flip-flops
   logic mapped;
   assign bus_wr = psel && penable && pready && pwrite;
   assign bus_rd = psel && penable && !pready && !pwrite;
   assign mapped = (paddr == psc_pkg::REG_CTRL) || (paddr == psc_pkg::REG_CFG) ||
                   (paddr == psc_pkg::REG_STAT) || (paddr == psc_pkg::REG_IRQ_STAT) ||
                   (paddr == psc_pkg::REG_IRQ_MASK) || (paddr == psc_pkg::REG_SHIFT);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !mapped;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_out_en_r <= psc_pkg::CTRL_OUT_EN_RST;
      end else if (bus_wr && paddr == psc_pkg::REG_CTRL) begin
         ctrl_out_en_r <= pwdata[psc_pkg::CTRL_OUT_EN_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_r <= psc_pkg::IRQ_MASK_RST;
      end else begin
         irq_mask_r <= irq_mask_nxt();
      end
   end

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h00000000;
      case (paddr)
         psc_pkg::REG_CTRL: rd_mux[psc_pkg::CTRL_OUT_EN_BIT] = ctrl_out_en_r;
         psc_pkg::REG_CFG: rd_mux[psc_pkg::FRAME_BITS-1:0] = cfg_r;
         psc_pkg::REG_STAT: begin
            rd_mux[psc_pkg::STAT_LOCKED_BIT] = !locked_n;
            rd_mux[psc_pkg::STAT_RUN_BIT] = out_running;
            rd_mux[psc_pkg::STAT_CODE_OK_BIT] = psc_pkg::code_ok(cfg_r.post_code);
            rd_mux[psc_pkg::STAT_OE_BIT] = oe_s;
            rd_mux[psc_pkg::STAT_STATE_LSB +: 3] = lk_st_r;
         end
         psc_pkg::REG_IRQ_STAT: rd_mux[psc_pkg::IRQ_W-1:0] = irq_stat_r;
         psc_pkg::REG_IRQ_MASK: rd_mux[psc_pkg::IRQ_W-1:0] = irq_mask_r;
         psc_pkg::REG_SHIFT: begin
            rd_mux[psc_pkg::FRAME_BITS-1:0] = shift_r;
            rd_mux[psc_pkg::SHIFT_CNT_LSB +: 5] = bit_cnt_r;
         end
         default: rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (bus_rd) begin
         prdata <= rd_mux;
      end
   end

endmodule
`default_nettype wire

// ===== rtl/psc_outdiv.sv
// Output divider and synchronous output gate of the synthesizer.
// Assumes osc_tick is a one-cycle pulse per oscillator period on clk and that
// out_en is already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none
module psc_outdiv (
   input wire logic clk, // Block clock
   input wire logic rst_n, // Asynchronous reset, active low
   input wire logic osc_tick, // One pulse per oscillator cycle
   input wire logic [psc_pkg::POSTDIV_W-1:0] post_code, // Output divider code
   input wire logic out_en, // Synchronised output enable
   output logic out_p, // True output
   output logic out_n, // Complement output
   output logic running // Output is toggling
);

   // ----------------------------------------------------------------
   // Divider
   // ----------------------------------------------------------------
   logic [psc_pkg::HALF_W-1:0] half;
   logic [psc_pkg::HALF_W-1:0] cnt_r;
   logic phase_r;
   logic wrap;

   assign half = psc_pkg::post_half(post_code); // R2 R3
   assign wrap = osc_tick && (half != 5'h00) && ((cnt_r + 5'h01) >= half);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 5'h00;
      end else if (half == 5'h00 || wrap) begin
         cnt_r <= 5'h00;
      end else if (osc_tick) begin
         cnt_r <= cnt_r + 5'h01;
      end
   end

   // Invalid code parks the phase low; the output gate holds the outputs at their disabled levels
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_r <= 1'b0;
      end else if (half == 5'h00) begin
         phase_r <= 1'b0; // R3
      end else if (wrap) begin
         phase_r <= ~phase_r; // R2
      end
   end

   // ----------------------------------------------------------------
   // Output gate
   // ----------------------------------------------------------------
   // The enable is only looked at on a rising phase, so the enable never cuts a pulse short
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_p <= 1'b0;
         out_n <= 1'b1;
         running <= 1'b0;
      end else if (half == 5'h00) begin
         out_p <= 1'b0;
         out_n <= 1'b1;
         running <= 1'b0;
      end else if (wrap && !phase_r) begin
         out_p <= out_en; // R7 R8
         out_n <= ~out_en; // R8
         running <= out_en;
      end else if (wrap) begin
         out_p <= 1'b0;
         out_n <= 1'b1;
      end
   end

endmodule
`default_nettype wire

// ===== rtl/psc_pkg.sv
// Package of the synthesizer frequency control block: register map, field layout,
// reset values, timing counts, configuration and event carriers.
// Assumes a 100 MHz APB clock; all users refer to names as psc_pkg::name.
package psc_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned LOCK_MAX_US = 5000;
   localparam int unsigned LOCK_TYP_US = 500;
   // Longest time, so rounded down; exact at this rate
   localparam int unsigned LOCK_MAX_CYC = LOCK_MAX_US * CLK_MHZ;
   localparam int unsigned LOCK_TYP_CYC = LOCK_TYP_US * CLK_MHZ;

   // ----------------------------------------------------------------
   // Divider widths and frame
   // ----------------------------------------------------------------
   localparam int unsigned PRESCALE_W = 5;
   localparam int unsigned FEEDBACK_W = 10;
   localparam int unsigned POSTDIV_W = 3;
   localparam int unsigned FRAME_BITS = PRESCALE_W + FEEDBACK_W + POSTDIV_W;
   localparam int unsigned HALF_W = 5;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_CFG = 8'h04;
   localparam logic [7:0] REG_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
   localparam logic [7:0] REG_IRQ_MASK = 8'h10;
   localparam logic [7:0] REG_SHIFT = 8'h14;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int unsigned CTRL_OUT_EN_BIT = 0;
   localparam int unsigned STAT_LOCKED_BIT = 0;
   localparam int unsigned STAT_RUN_BIT = 1;
   localparam int unsigned STAT_CODE_OK_BIT = 2;
   localparam int unsigned STAT_OE_BIT = 3;
   localparam int unsigned STAT_STATE_LSB = 4;
   localparam int unsigned SHIFT_CNT_LSB = 20;
   localparam int unsigned IRQ_W = 6;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic CTRL_OUT_EN_RST = 1'b1;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 6'h00;
   localparam logic [FRAME_BITS-1:0] CFG_RST = 18'h00000;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   // Serial frame: post code msb first, then feedback, then prescale
   typedef struct packed {
      logic [POSTDIV_W-1:0] post_code;
      logic [FEEDBACK_W-1:0] feedback;
      logic [PRESCALE_W-1:0] prescale;
   } psc_cfg_t;

   typedef struct packed {
      logic bad_code;
      logic frame_err;
      logic lock_timeout;
      logic lock_lost;
      logic lock_gained;
      logic cfg_loaded;
   } psc_irq_t;

   typedef enum logic [2:0] {
      LK_IDLE = 3'b001,
      LK_ACQ = 3'b010,
      LK_LOCKED = 3'b100
   } psc_lock_st_t;

   // Half period of the output in oscillator cycles; zero for a code that is not valid
   function automatic logic [HALF_W-1:0] post_half(input logic [POSTDIV_W-1:0] code);
      case (code)
         3'h1: post_half = 5'h01;
         3'h2: post_half = 5'h02;
         3'h3: post_half = 5'h04;
         3'h4: post_half = 5'h08;
         3'h5: post_half = 5'h10;
         default: post_half = 5'h00;
      endcase
   endfunction

   function automatic logic code_ok(input logic [POSTDIV_W-1:0] code);
      code_ok = (post_half(code) != 5'h00);
   endfunction

endpackage
